// >>> shared/amat_cfg.svh
// Constants of the asynchronous memory access timing block.
// Assumes inclusion by the package and the design module only.
`ifndef AMAT_CFG_SVH
`define AMAT_CFG_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define AMAT_NUM_SPACES     4
`define AMAT_SPACE_W        2
`define AMAT_ADDR_W         22

// ----------------------------------------------------------------
// Register byte offsets, space block base and sub-register indices
// ----------------------------------------------------------------
`define AMAT_OFS_GLOBAL     12'h000
`define AMAT_OFS_TIMEOUT    12'h004
`define AMAT_OFS_ERRSTAT    12'h008
`define AMAT_OFS_SPACE_BASE 4'h1
`define AMAT_SUB_CTL1       2'h0
`define AMAT_SUB_CTL2       2'h1
`define AMAT_SUB_CTL3       2'h2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AMAT_G_READY_OFF    0
`define AMAT_G_POST_EN      1
`define AMAT_G_GRANT_BLOCK  2
`define AMAT_E_TIMEOUT      0
`define AMAT_E_FROM_DMA     1
`define AMAT_C1_KIND        2:0
`define AMAT_C1_RD_EXHOLD   6:4
`define AMAT_C1_WR_EXHOLD   10:8
`define AMAT_C23_SETUP      3:0
`define AMAT_C23_STROBE     9:4
`define AMAT_C23_HOLD       12:10

// ----------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------
`define AMAT_KIND_ASYNC8    3'h0
`define AMAT_KIND_ASYNC16   3'h1
`define AMAT_KIND_ASYNC32   3'h2
`define AMAT_SETUP_SHORT    4'h3
`define AMAT_SETUP_FIRST    6'h02
`define AMAT_SETUP_NEXT     6'h01
`define AMAT_RST_GLOBAL     3'h0
`define AMAT_RST_TIMEOUT    8'h00
`define AMAT_RST_CTL1       16'h0000
`define AMAT_RST_CTL23      16'hffff

`endif

// >>> shared/amat_pkg.sv
// Types of the asynchronous memory access timing block.
// Assumes amat_cfg.svh is on the include path.
`include "amat_cfg.svh"

package amat_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD,
        ST_EXHOLD
    } amat_state_t;

    typedef logic [`AMAT_NUM_SPACES-1:0][15:0] amat_ctl_t;

    typedef struct packed {
        amat_state_t                st;
        logic [5:0]                 cnt;
        logic [7:0]                 wait_cnt;
        logic                       wr;
        logic                       dma;
        logic [`AMAT_SPACE_W-1:0]   space;
        logic [`AMAT_ADDR_W-1:0]    addr;
        logic [31:0]                wdata;
        logic [3:0]                 be_n;
        logic [2:0]                 gctl;
        logic [7:0]                 tout;
        logic [1:0]                 err;
        amat_ctl_t                  c1;
        amat_ctl_t                  c2;
        amat_ctl_t                  c3;
        logic [`AMAT_NUM_SPACES-1:0] ce_n;
        logic                       oe_n;
        logic                       re_n;
        logic                       we_n;
        logic                       dq_oe_n;
        logic [`AMAT_ADDR_W-1:0]    a;
        logic [3:0]                 be_pin_n;
        logic [31:0]                dq_out;
        logic                       rsp_done;
        logic                       rsp_err;
        logic [31:0]                rdata;
        logic                       irq;
        logic                       dma_to;
        logic [31:0]                prdata;
        logic                       pslverr;
        logic [2:0]                 rdy_s;
        logic                       rdy_q;
    } amat_regs_t;

endpackage : amat_pkg

// >>> design/amat_ctrl.sv
// Asynchronous memory timing engine with APB register file.
// Assumes one requester port shared by CPU buses and DMA, arbitrated
// upstream; the memory data bus is split into in, out and enable.
//
// Overview of operation
// R1: Address pins start at bit 0, 1 or 2 by width; bit 21 on top.
// R2: Kind 000b is 8-bit, 001b 16-bit, 010b 32-bit asynchronous memory.
// R3: Writes to an 8-bit space are refused and never reach the pins.
// R4: Every space owns three control registers of its own.
// R5: Timing fields act only when the space kind is asynchronous.
// R6: Address, enables and read output enable lead the strobe by setup cycles.
// R7: Strobe stays low for the programmed read or write strobe count.
// R8: Address and enables stay for hold cycles after strobe rises.
// R9: Extended hold, all chip enables off, before space or direction change.
// R10: Extended hold lasts programmed value plus one cycle.
// R11: Setup 0..2 gives 2 first and 1 later; 3..15 exact.
// R12: Memory pulls ready low while it is not ready.
// R13: Cycles with ready sampled low are counted against one time-out.
// R14: Reaching the time-out records an error in the error status.
// R15: CPU-requested time-out raises a bus-error interrupt request.
// R16: DMA-requested time-out signals the DMA controller instead.
// R17: One global bit disables the ready input for all spaces.
// R18: With ready disabled it is not sampled and no time-out occurs.
// R19: One global bit enables write posting for all spaces.
// R20: One global bit blocks external bus hold for all spaces.
// R21: Read data is taken on the edge ending the strobe period.
// R22: Memory may stretch only strobes of at least four cycles.
// R23: A same space and direction request aborts the extended hold.
// R24: The not-ready counter clears at the start of every access.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "amat_cfg.svh"

module amat_ctrl
    import amat_pkg::*;
(
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         ce,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [11:0]                  paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         req_valid,
    input  wire logic                         req_write,
    input  wire logic                         req_dma,
    input  wire logic [`AMAT_SPACE_W-1:0]     req_space,
    input  wire logic [`AMAT_ADDR_W-1:0]      req_addr,
    input  wire logic [3:0]                   req_be_n,
    input  wire logic [31:0]                  req_wdata,
    output logic                              req_ready,
    output logic                              rsp_done,
    output logic                              rsp_err,
    output logic      [31:0]                  rsp_rdata,
    output logic                              bus_error_irq,
    output logic                              dma_timeout,
    output logic                              write_posting_enable,
    output logic                              bus_grant_block,
    output logic      [`AMAT_ADDR_W-1:0]      mem_addr,
    output logic      [`AMAT_NUM_SPACES-1:0]  chip_enable_n,
    output logic      [3:0]                   byte_enable_n,
    output logic                              output_enable_n,
    output logic                              read_strobe_n,
    output logic                              write_strobe_n,
    output logic      [31:0]                  mem_data_out,
    output logic                              mem_data_oe_n,
    input  wire logic [31:0]                  mem_data_in,
    input  wire logic                         memory_ready_in
);

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function automatic logic kind_is_async(input logic [2:0] k);
        return (k == `AMAT_KIND_ASYNC8) || (k == `AMAT_KIND_ASYNC16)
            || (k == `AMAT_KIND_ASYNC32);                              // [R2] [R5]
    endfunction : kind_is_async
    function automatic logic [5:0] setup_len(input logic [3:0] v, input logic first);
        if (v < `AMAT_SETUP_SHORT)
            return first ? `AMAT_SETUP_FIRST : `AMAT_SETUP_NEXT;       // [R11]
        return {2'b00, v};
    endfunction : setup_len
    function automatic logic [5:0] at_least_one(input logic [5:0] v);
        return (v == 6'h00) ? 6'h01 : v;
    endfunction : at_least_one

    amat_regs_t r;
    amat_regs_t n;
    logic [2:0]  req_kind;
    logic        req_bad;
    logic        same_type;
    logic        hold_end;
    logic        take;
    logic        refuse;
    logic [15:0] tim;
    logic        ready_used;
    logic        apb_setup;
    logic        apb_wr;
    logic [3:0]  pa_blk;
    logic [1:0]  pa_sub;
    logic [`AMAT_SPACE_W-1:0] pa_space;
    logic        pa_space_ok;

    assign req_kind    = r.c1[req_space][`AMAT_C1_KIND];
    assign req_bad     = !kind_is_async(req_kind)                      // [R5]
                       || (req_write && req_kind == `AMAT_KIND_ASYNC8); // [R3]
    assign same_type   = req_valid && req_space == r.space && req_write == r.wr;
    assign hold_end    = r.st == ST_HOLD && r.cnt == 6'h00;
    assign ready_used  = !r.gctl[`AMAT_G_READY_OFF];                   // [R17]
    assign tim         = r.wr ? r.c3[r.space] : r.c2[r.space];
    assign pa_blk      = paddr[7:4];
    assign pa_sub      = paddr[3:2];
    assign pa_space    = `AMAT_SPACE_W'(pa_blk - `AMAT_OFS_SPACE_BASE);
    assign pa_space_ok = paddr[11:8] == 4'h0 && pa_blk >= `AMAT_OFS_SPACE_BASE
                       && pa_blk < 4'(`AMAT_NUM_SPACES + 1) && pa_sub != 2'h3;
    assign apb_setup   = psel && !penable;
    assign apb_wr      = psel && penable && pwrite;
    // Refused requests answer from idle only, so an error never overtakes data
    assign req_ready = ce && (r.st == ST_IDLE
                     || ((hold_end || r.st == ST_EXHOLD) && same_type && !req_bad)); // [R23]
    assign take      = req_valid && req_ready && !req_bad;
    assign refuse    = req_valid && req_ready && req_bad;              // [R3]

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [15:0] nt;
        logic        tmo;
        nt  = 16'h0000;
        tmo = 1'b0;
        n   = r;
        n.rsp_done = 1'b0;
        n.rsp_err  = 1'b0;
        n.irq      = 1'b0;
        n.dma_to   = 1'b0;

        // Ready pin: three stages, a change counts once the last two agree
        n.rdy_s = {r.rdy_s[1:0], memory_ready_in};
        if (r.rdy_s[2] == r.rdy_s[1])
            n.rdy_q = r.rdy_s[2];

        case (r.st)
            ST_IDLE: begin
                if (refuse) begin
                    n.rsp_done = 1'b1;
                    n.rsp_err  = 1'b1;
                end
            end
            ST_SETUP: begin
                if (r.cnt == 6'h00) begin
                    n.st  = ST_STROBE;                                 // [R6]
                    n.cnt = at_least_one(tim[`AMAT_C23_STROBE]) - 6'h01;
                end else begin
                    n.cnt = r.cnt - 6'h01;
                end
            end
            ST_STROBE: begin
                if (r.cnt != 6'h00) begin
                    n.cnt = r.cnt - 6'h01;                             // [R7]
                end else if (ready_used && !r.rdy_q) begin             // [R18]
                    n.wait_cnt = r.wait_cnt + 8'h01;                   // [R13]
                    tmo = r.tout != 8'h00 && n.wait_cnt == r.tout;
                end
                if (r.cnt == 6'h00 && (!ready_used || r.rdy_q || tmo)) begin
                    n.st  = ST_HOLD;
                    n.cnt = at_least_one({3'b000, tim[`AMAT_C23_HOLD]}) - 6'h01; // [R8]
                    n.rsp_err = tmo;
                    if (!r.wr)
                        n.rdata = mem_data_in;                         // [R21]
                end
                if (tmo) begin
                    n.irq    = !r.dma;                                 // [R15]
                    n.dma_to = r.dma;                                  // [R16]
                end
            end
            ST_HOLD: begin
                if (r.cnt == 6'h00) begin
                    n.rsp_done = 1'b1;
                    n.st  = ST_EXHOLD;                                 // [R9]
                    n.cnt = {3'b000, r.wr ? r.c1[r.space][`AMAT_C1_WR_EXHOLD]
                                          : r.c1[r.space][`AMAT_C1_RD_EXHOLD]}; // [R10]
                end else begin
                    n.cnt = r.cnt - 6'h01;
                end
                // Time-out error rides through hold and leaves with rsp_done
                n.rsp_err = r.rsp_err;                                 // [R14]
            end
            ST_EXHOLD: begin
                if (r.cnt == 6'h00)
                    n.st = ST_IDLE;
                else
                    n.cnt = r.cnt - 6'h01;
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase
        if (take) begin
            nt = req_write ? r.c3[req_space] : r.c2[req_space];        // [R4]
            n.st       = ST_SETUP;
            n.cnt      = setup_len(nt[`AMAT_C23_SETUP], r.st != ST_HOLD) - 6'h01; // [R11]
            n.wait_cnt = 8'h00;                                        // [R24]
            n.wr       = req_write;
            n.dma      = req_dma;
            n.space    = req_space;
            n.addr     = req_addr;
            n.wdata    = req_wdata;
            n.be_n     = req_be_n;
        end

        // Pins follow the next state so that they leave flip-flops
        n.ce_n     = '1;
        n.oe_n     = 1'b1;
        n.re_n     = 1'b1;
        n.we_n     = 1'b1;
        n.dq_oe_n  = 1'b1;
        if (n.st == ST_SETUP || n.st == ST_STROBE || n.st == ST_HOLD) begin
            n.ce_n[n.space] = 1'b0;
            n.oe_n     = n.wr;                                         // [R6] [R8]
            n.dq_oe_n  = !n.wr;
            n.re_n     = !(n.st == ST_STROBE && !n.wr);
            n.we_n     = !(n.st == ST_STROBE && n.wr);                 // [R3]
            n.be_pin_n = n.be_n;
            n.dq_out   = n.wdata;
            n.a        = n.addr;
            case (r.c1[n.space][`AMAT_C1_KIND])
                `AMAT_KIND_ASYNC16: n.a[0]   = 1'b0;                   // [R1]
                `AMAT_KIND_ASYNC32: n.a[1:0] = 2'b00;                  // [R1]
                default:            n.a      = n.addr;
            endcase
        end

        // ------------------------------------------------------------
        // APB register file
        // ------------------------------------------------------------
        n.pslverr = 1'b0;
        if (apb_setup) begin
            n.prdata  = 32'h0000_0000;
            case (paddr)
                `AMAT_OFS_GLOBAL:  n.prdata = {29'h0, r.gctl};
                `AMAT_OFS_TIMEOUT: n.prdata = {24'h0, r.tout};
                `AMAT_OFS_ERRSTAT: n.prdata = {30'h0, r.err};
                default: begin
                    if (!pa_space_ok)
                        n.pslverr = 1'b1;
                    else if (pa_sub == `AMAT_SUB_CTL1)
                        n.prdata = {16'h0, r.c1[pa_space]};
                    else if (pa_sub == `AMAT_SUB_CTL2)
                        n.prdata = {16'h0, r.c2[pa_space]};
                    else
                        n.prdata = {16'h0, r.c3[pa_space]};
                end
            endcase
        end else if (psel && penable) begin
            n.pslverr = r.pslverr;
        end
        if (apb_wr) begin
            case (paddr)
                `AMAT_OFS_GLOBAL:  n.gctl = pwdata[2:0];               // [R17] [R19] [R20]
                `AMAT_OFS_TIMEOUT: n.tout = pwdata[7:0];
                `AMAT_OFS_ERRSTAT: n.err  = r.err & ~pwdata[1:0];
                default: begin
                    if (pa_space_ok && pa_sub == `AMAT_SUB_CTL1)
                        n.c1[pa_space] = pwdata[15:0];
                    else if (pa_space_ok && pa_sub == `AMAT_SUB_CTL2)
                        n.c2[pa_space] = pwdata[15:0];
                    else if (pa_space_ok)
                        n.c3[pa_space] = pwdata[15:0];
                end
            endcase
        end
        // Hardware set beats a clear written in the same cycle
        if (tmo) begin
            n.err[`AMAT_E_TIMEOUT]  = 1'b1;                            // [R14]
            n.err[`AMAT_E_FROM_DMA] = r.dma;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r          <= '0;
            r.gctl     <= `AMAT_RST_GLOBAL;
            r.tout     <= `AMAT_RST_TIMEOUT;
            r.c1       <= {`AMAT_NUM_SPACES{`AMAT_RST_CTL1}};
            r.c2       <= {`AMAT_NUM_SPACES{`AMAT_RST_CTL23}};
            r.c3       <= {`AMAT_NUM_SPACES{`AMAT_RST_CTL23}};
            r.ce_n     <= '1;
            r.oe_n     <= 1'b1;
            r.re_n     <= 1'b1;
            r.we_n     <= 1'b1;
            r.dq_oe_n  <= 1'b1;
            r.be_pin_n <= 4'hf;
            r.rdy_s    <= 3'h7;
            r.rdy_q    <= 1'b1;
        end else if (ce) begin
            r <= n;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata               = r.prdata;
    assign pready               = 1'b1;
    assign pslverr              = r.pslverr && psel && penable;
    assign rsp_done             = r.rsp_done;
    assign rsp_err              = r.rsp_err && r.rsp_done;
    assign rsp_rdata            = r.rdata;
    assign bus_error_irq        = r.irq;
    assign dma_timeout          = r.dma_to;
    assign write_posting_enable = r.gctl[`AMAT_G_POST_EN];             // [R19]
    assign bus_grant_block      = r.gctl[`AMAT_G_GRANT_BLOCK];         // [R20]
    assign mem_addr             = r.a;
    assign chip_enable_n        = r.ce_n;
    assign byte_enable_n        = r.be_pin_n;
    assign output_enable_n      = r.oe_n;
    assign read_strobe_n        = r.re_n;
    assign write_strobe_n       = r.we_n;
    assign mem_data_out         = r.dq_out;
    assign mem_data_oe_n        = r.dq_oe_n;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !ce);
    chk_exhold_ce_off: assert property (r.st == ST_EXHOLD |-> &r.ce_n) // [R9]
        else $error("chip enable active in extended hold");
    chk_no_byte_write: assert property (
        !write_strobe_n |-> r.c1[r.space][`AMAT_C1_KIND] != `AMAT_KIND_ASYNC8) // [R3]
        else $error("write strobe on 8-bit space");
    chk_setup_first: assert property (
        (r.st == ST_IDLE && take && r.c2[req_space][3:0] < 4'h3 && !req_write)
        ##1 $stable(ce) |-> r.cnt == 6'h01)                            // [R11]
        else $error("first short setup not two cycles");
    chk_oe_setup_rd: assert property (
        r.st == ST_SETUP && !r.wr |-> !output_enable_n && read_strobe_n) // [R6]
        else $error("output enable wrong in read setup");
    chk_strobe_low: assert property (
        r.st == ST_STROBE && r.wr |-> !write_strobe_n && !chip_enable_n[r.space]) // [R7]
        else $error("write strobe not low in strobe period");
    chk_timeout_flag: assert property (
        $rose(bus_error_irq) || $rose(dma_timeout) |-> r.err[`AMAT_E_TIMEOUT]) // [R14]
        else $error("time-out not recorded");
    chk_irq_route: assert property (
        !(bus_error_irq && dma_timeout))                               // [R16]
        else $error("time-out routed both ways");
    chk_ready_off: assert property (
        r.gctl[`AMAT_G_READY_OFF] && $past(r.gctl[`AMAT_G_READY_OFF])
        |-> !bus_error_irq && !dma_timeout)                            // [R18]
        else $error("time-out with ready disabled");
    chk_wait_clear: assert property (
        take |=> r.wait_cnt == 8'h00 && r.st == ST_SETUP)              // [R24]
        else $error("not-ready count not cleared");
    chk_exhold_len: assert property (
        hold_end && !take && r.c1[r.space][6:4] == 3'h0 && !r.wr
        |=> r.st == ST_EXHOLD ##1 r.st != ST_EXHOLD)                   // [R10]
        else $error("extended hold not one cycle");
    cov_read:    cover property (r.st == ST_STROBE && !r.wr ##1 r.st == ST_HOLD);
    cov_write:   cover property (r.st == ST_STROBE && r.wr ##1 r.st == ST_HOLD);
    cov_abort:   cover property (r.st == ST_EXHOLD && take);
    cov_timeout: cover property (bus_error_irq || dma_timeout);

endmodule : amat_ctrl

// >>> verification/amat_mem_model.sv
// Behavioural asynchronous memory chip facing the timing engine.
// Assumes word addresses in the low 256 bytes and a stall input from the bench.
`timescale 1ns/1ps
module amat_mem_model (
    input  wire logic        pclk,
    input  wire logic [3:0]  chip_enable_n,
    input  wire logic        output_enable_n,
    input  wire logic        write_strobe_n,
    input  wire logic [21:0] mem_addr,
    input  wire logic [31:0] mem_data_out,
    input  wire logic        stall,
    output logic      [31:0] mem_data_in,
    output logic             memory_ready_in
);
    logic [31:0] mem [64];
    logic [31:0] last_q = 32'h0;
    initial for (int i = 0; i < 64; i++) mem[i] = 32'ha5000000 | i;
    // Released bus shows the inverse of its last value, so stale data never matches
    assign mem_data_in = (~&chip_enable_n && !output_enable_n) ? mem[mem_addr[7:2]] : ~last_q;
    // Stall is only commanded with strobes of four cycles or more
    assign memory_ready_in = ~stall;
    always @(posedge pclk) begin
        if (~&chip_enable_n && !output_enable_n) last_q <= mem_data_in;
        if (~&chip_enable_n && !write_strobe_n) mem[mem_addr[7:2]] <= mem_data_out;
    end
endmodule : amat_mem_model

// >>> verification/test_async_memory_access_timing.sv
// Self-checking bench for the asynchronous memory timing engine.
// Assumes amat_pkg is compiled first and the memory model beside it.
`timescale 1ns/1ps
module test_async_memory_access_timing import amat_pkg::*; ;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, stall = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, req_wdata = 0, rsp_rdata, mem_data_out, mem_data_in, d;
    logic pready, pslverr, req_valid = 0, req_write = 0, req_dma = 0, req_ready, rsp_done;
    logic rsp_err, bus_error_irq, dma_timeout, write_posting_enable, bus_grant_block;
    logic read_strobe_n, write_strobe_n, output_enable_n, mem_data_oe_n, memory_ready_in;
    logic [1:0] req_space = 0;
    logic [21:0] req_addr = 0, mem_addr, a;
    logic [3:0] req_be_n = 0, chip_enable_n, byte_enable_n;
    logic [33:0] exp_q[$];
    logic [33:0] n;
    int errors, num_checks, su, st, last_su, last_st, last_hd, irqs, dmas;
    int seed = 32'h1814;
    amat_ctrl amat_ctrl_i (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .req_valid, .req_write, .req_dma, .req_space, .req_addr,
        .req_be_n, .req_wdata, .req_ready, .rsp_done, .rsp_err, .rsp_rdata, .bus_error_irq,
        .dma_timeout, .write_posting_enable, .bus_grant_block, .mem_addr, .chip_enable_n,
        .byte_enable_n, .output_enable_n, .read_strobe_n, .write_strobe_n, .mem_data_out,
        .mem_data_oe_n, .mem_data_in, .memory_ready_in);
    amat_mem_model amat_mem_model_i (.pclk, .chip_enable_n, .output_enable_n, .write_strobe_n,
        .mem_addr, .mem_data_out, .stall, .mem_data_in, .memory_ready_in);
    initial forever #5 pclk = ~pclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd, ex,
                       input logic xe);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        if (!w) chk(prdata, ex);
        chk(32'(pslverr), 32'(xe));
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic req(input logic w, dm, input logic [1:0] sp, input logic [33:0] note);
        exp_q.push_back(note);
        @(posedge pclk);
        req_valid <= 1;
        req_write <= w;
        req_dma <= dm;
        req_space <= sp;
        req_addr <= a;
        req_wdata <= d;
        do @(posedge pclk); while (req_ready !== 1'b1);
        req_valid <= 0;
    endtask : req
    task automatic drain();
        for (int i = 0; i < 600 && exp_q.size() != 0; i++) @(posedge pclk);
        if (exp_q.size() != 0) begin
            errors++;
            $display("[FAIL] %0t response missing", $time);
        end
    endtask : drain
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    // Setup counts only hold for first accesses, where no hold precedes them
    always @(posedge pclk) begin
        if (rsp_done === 1'b1 && exp_q.size() != 0) begin
            n = exp_q.pop_front();
            chk(32'(rsp_err), 32'(n[32]));
            if (n[33]) chk(rsp_rdata, n[31:0]);
        end
        if (!chip_enable_n[1]) chk(32'(mem_addr[1:0]), 32'h0);
        if (!chip_enable_n[1]) chk(32'(byte_enable_n), 32'(req_be_n));
        if (!write_strobe_n) chk(32'(mem_data_oe_n), 32'h0);
        irqs += (bus_error_irq === 1'b1);
        dmas += (dma_timeout === 1'b1);
        if (!read_strobe_n || !write_strobe_n) begin
            if (st == 0) last_su = su;
            st++;
            su = 0;
        end else begin
            if (st != 0) last_st = st;
            st = 0;
            if (&chip_enable_n && su != 0) last_hd = su;
            su = (&chip_enable_n) ? 0 : su + 1;
        end
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        apb(0, 12'h000, 0, 32'h0, 0);
        apb(0, 12'h014, 0, 32'hffff, 0);
        apb(0, 12'h010, 0, 32'h0, 0);
        apb(0, 12'h01c, 0, 32'h0, 1);
        $display("Registers done");
        a = 22'h10;
        req(1, 0, 2'h0, {2'b01, 32'h0});
        req(0, 0, 2'h0, {2'b00, 32'h0});
        drain();
        chk(last_su, 15);
        chk(last_st, 63);
        chk(last_hd, 7);
        $display("Byte space done");
        apb(1, 12'h020, 32'h2, 0, 0);
        apb(1, 12'h024, 32'h0441, 0, 0);
        apb(1, 12'h028, 32'h0441, 0, 0);
        d = $random(seed);
        a = {14'h0, d[13:8], 2'b11};
        req(1, 0, 2'h1, {2'b00, 32'h0});
        req(0, 0, 2'h1, {2'b10, d});
        drain();
        chk(last_su, 2);
        chk(last_st, 4);
        chk(last_hd, 1);
        apb(1, 12'h030, 32'h5, 0, 0);
        req(0, 0, 2'h2, {2'b01, 32'h0});
        $display("Word space done");
        apb(1, 12'h004, 32'h3, 0, 0);
        stall <= 1;
        req(0, 0, 2'h1, {2'b01, 32'h0});
        drain();
        chk(irqs, 1);
        apb(0, 12'h008, 0, 32'h1, 0);
        apb(1, 12'h008, 32'h3, 0, 0);
        req(0, 1, 2'h1, {2'b01, 32'h0});
        drain();
        chk(dmas + irqs * 2, 3);
        apb(0, 12'h008, 0, 32'h3, 0);
        $display("Time-out done");
        apb(1, 12'h000, 32'h7, 0, 0);
        req(0, 0, 2'h1, {2'b10, d});
        drain();
        chk(32'({write_posting_enable, bus_grant_block}), 32'h3);
        $display("Global bits done");
        wrap_up();
    end
    initial begin
        #100us;
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end
endmodule : test_async_memory_access_timing
